// File: pkg/rsws_consts.svh
// constants for the rtc snapshot and write-sync status block
`ifndef RSWS_CONSTS_SVH
`define RSWS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSWS_OFF_STATUS 8'h00
`define RSWS_OFF_CTRL 8'h04
`define RSWS_OFF_TRIM 8'h08
`define RSWS_OFF_ALARM_A 8'h0C
`define RSWS_OFF_ALARM_B 8'h10
`define RSWS_OFF_CNT_LOW 8'h14
`define RSWS_OFF_CNT_MID 8'h18
`define RSWS_OFF_GATEWAY 8'h1C
`define RSWS_OFF_CAPCTRL 8'h20
`define RSWS_OFF_SNAP_LOW 8'h24
`define RSWS_OFF_SNAP_MID 8'h28
`define RSWS_OFF_SNAP_HIGH 8'h2C
`define RSWS_OFF_IRQ_STAT 8'h30
`define RSWS_OFF_IRQ_MASK 8'h34

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define RSWS_SNAP_KEY 16'h7627
`define RSWS_BIT_WSYNC_FLAG 5
`define RSWS_BIT_SYNC_FIRST 7
`define RSWS_BIT_VISIBLE 14
`define RSWS_CAP_EN_BIT 0
`define RSWS_CAP_OW_BIT 1
`define RSWS_IRQ_SNAP_BIT 0
`define RSWS_IRQ_WSYNC_BIT 1
`define RSWS_SYNC_DELAY 4

`endif

// File: pkg/rsws_pkg.sv
// types shared by the rtc snapshot and write-sync status block
package rsws_pkg;
	// one 16-bit register word
	typedef logic [15:0] rsws_word_t;
	// posted-write targets, index i maps to status bit 7+i
	typedef enum logic [2:0] {
		RSWS_TGT_CTRL = 3'h0,
		RSWS_TGT_STATUS = 3'h1,
		RSWS_TGT_CNT_LOW = 3'h2,
		RSWS_TGT_CNT_MID = 3'h3,
		RSWS_TGT_ALARM_A = 3'h4,
		RSWS_TGT_ALARM_B = 3'h5,
		RSWS_TGT_TRIM = 3'h6
	} rsws_target_e;
endpackage

// File: core/rsws_core.sv
// apb register block: counter snapshots and posted-write sync status
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsws_consts.svh"

// Contract
// - gateway key write loads all three snapshots
// - enabled capture event loads snapshots if overwrite allowed
// - low snapshot holds counter low word
// - middle snapshot holds counter middle word
// - upper snapshot holds counter upper fifteen bits
// - snapshots form 47-bit capture, low mid upper
// - status bit 14 shows always-on visibility
// - status bit 13 low while trim write pending
// - status bit 12 low while alarm b pending
// - status bit 11 low while alarm a pending
// - status bit 10 low while counter mid pending
// - status bit 9 low while counter low pending
// - status bit 8 low while status write pending
// - status bit 7 low while control write pending
// - status carries no interrupt or error flags
// - bit 5 sticky on sync completion, write-one clears
module rsws_core #(
	parameter int SYNC_DELAY = `RSWS_SYNC_DELAY,
	parameter int HIGH_BITS = 15
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// counter words from the always-on side
	input wire rsws_pkg::rsws_word_t counterLowWord,
	input wire rsws_pkg::rsws_word_t counterMidWord,
	input wire logic [HIGH_BITS-1:0] counterHighWord,
	// capture channel 0 event, one-cycle pulse
	input wire logic captureEvent,
	// isolation state, high when always-on registers are visible
	input wire logic alwaysOnVisibleIn,
	// pulse per posted target when its write takes effect
	output logic [6:0] postedWriteDone,
	output logic irq
);
	import rsws_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (SYNC_DELAY < 1 || SYNC_DELAY > 255) begin : gChkDelay
		$error("SYNC_DELAY must lie in 1..255");
	end
	if (HIGH_BITS != 15) begin : gChkHigh
		$error("HIGH_BITS must be 15 for a 47-bit capture");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	rsws_word_t snapLow; // low snapshot
	rsws_word_t snapMid; // middle snapshot
	logic [HIGH_BITS-1:0] snapHigh; // upper snapshot
	logic [1:0] captureControl; // enable, overwrite enable
	logic [6:0] pending; // posted writes not yet visible
	logic [7:0] syncCount [0:6]; // per-target crossing delay
	rsws_word_t postedData [0:6]; // last posted value per target
	logic wsyncFlag; // sticky sync-complete flag
	logic alwaysOnVisible; // sampled isolation state
	logic [1:0] irqStatus; // read-clear event bits
	logic [1:0] irqMask; // interrupt enables

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic setupPhase; // first cycle of a transfer
	logic accessDone; // transfer completes at this edge
	logic wrDone; // write completes
	logic rdDone; // read completes
	logic keyWrite; // gateway key written
	logic captureLoad; // capture allowed to replace snapshot
	logic snapLoad; // any snapshot event
	logic [6:0] postedHit; // write to a posted target
	logic [6:0] syncFinish; // posted write becomes visible
	logic statusWrite; // write to the status register
	logic [15:0] statusWord; // assembled status value
	logic addrOk; // mapped address
	logic [31:0] next_prdata; // read mux
	logic [2:0] postedIdx; // target index from address

	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready;
	assign wrDone = accessDone && pwrite;
	assign rdDone = accessDone && !pwrite;
	assign statusWrite = wrDone && (paddr == `RSWS_OFF_STATUS);
	assign keyWrite = wrDone && (paddr == `RSWS_OFF_GATEWAY)
		&& (pwdata[15:0] == `RSWS_SNAP_KEY);
	assign captureLoad = captureEvent && captureControl[`RSWS_CAP_EN_BIT]
		&& captureControl[`RSWS_CAP_OW_BIT];
	assign snapLoad = keyWrite || captureLoad;

	// map a posted-register address to its target index
	always_comb begin
		postedIdx = 3'h0;
		if (paddr == `RSWS_OFF_CTRL) begin
			postedIdx = RSWS_TGT_CTRL;
		end else if (paddr == `RSWS_OFF_STATUS) begin
			postedIdx = RSWS_TGT_STATUS;
		end else if (paddr == `RSWS_OFF_CNT_LOW) begin
			postedIdx = RSWS_TGT_CNT_LOW;
		end else if (paddr == `RSWS_OFF_CNT_MID) begin
			postedIdx = RSWS_TGT_CNT_MID;
		end else if (paddr == `RSWS_OFF_ALARM_A) begin
			postedIdx = RSWS_TGT_ALARM_A;
		end else if (paddr == `RSWS_OFF_ALARM_B) begin
			postedIdx = RSWS_TGT_ALARM_B;
		end else if (paddr == `RSWS_OFF_TRIM) begin
			postedIdx = RSWS_TGT_TRIM;
		end
	end

	// read mux and address check
	always_comb begin
		next_prdata = 32'h0000_0000;
		addrOk = 1'b1;
		if (paddr == `RSWS_OFF_STATUS) begin
			next_prdata = {16'h0000, statusWord};
		end else if (paddr == `RSWS_OFF_CTRL || paddr == `RSWS_OFF_TRIM
			|| paddr == `RSWS_OFF_ALARM_A || paddr == `RSWS_OFF_ALARM_B
			|| paddr == `RSWS_OFF_CNT_LOW || paddr == `RSWS_OFF_CNT_MID) begin
			next_prdata = {16'h0000, postedData[postedIdx]};
		end else if (paddr == `RSWS_OFF_GATEWAY) begin
			next_prdata = 32'h0000_0000; // gateway reads zero
		end else if (paddr == `RSWS_OFF_CAPCTRL) begin
			next_prdata = {30'h0000_0000, captureControl};
		end else if (paddr == `RSWS_OFF_SNAP_LOW) begin
			next_prdata = {16'h0000, snapLow};
		end else if (paddr == `RSWS_OFF_SNAP_MID) begin
			next_prdata = {16'h0000, snapMid};
		end else if (paddr == `RSWS_OFF_SNAP_HIGH) begin
			next_prdata = {17'h0_0000, snapHigh};
		end else if (paddr == `RSWS_OFF_IRQ_STAT) begin
			next_prdata = {30'h0000_0000, irqStatus};
		end else if (paddr == `RSWS_OFF_IRQ_MASK) begin
			next_prdata = {30'h0000_0000, irqMask};
		end else begin
			addrOk = 1'b0;
		end
	end

	// status word: visibility, sync bits, sticky flag
	always_comb begin
		statusWord = 16'h0000;
		statusWord[`RSWS_BIT_VISIBLE] = alwaysOnVisible;
		statusWord[`RSWS_BIT_SYNC_FIRST +: 7] = ~pending;
		statusWord[`RSWS_BIT_WSYNC_FLAG] = wsyncFlag;
	end

	// ----------------------------------------
	// apb answer, one access cycle, no waits
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= setupPhase;
			pslverr <= setupPhase && !addrOk;
			prdata <= (setupPhase && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// snapshots, written only by snapshot events
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			snapLow <= 16'h0000;
			snapMid <= 16'h0000;
			snapHigh <= '0;
		end else if (ce && snapLoad) begin
			snapLow <= counterLowWord;
			snapMid <= counterMidWord;
			snapHigh <= counterHighWord;
		end
	end

	// capture control register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			captureControl <= 2'h0;
		end else if (ce && wrDone && paddr == `RSWS_OFF_CAPCTRL) begin
			captureControl <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// posted writes and their crossing delay
	// ----------------------------------------
	for (genvar i = 0; i < 7; i++) begin : gPosted
		assign postedHit[i] = wrDone && addrOk && (postedIdx == 3'(i))
			&& paddr != `RSWS_OFF_GATEWAY && paddr != `RSWS_OFF_CAPCTRL
			&& paddr < `RSWS_OFF_GATEWAY;
		assign syncFinish[i] = pending[i] && (syncCount[i] == 8'h01);

		// a new write restarts the delay; effect visible when it ends
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				pending[i] <= 1'b0;
				syncCount[i] <= 8'h00;
				postedData[i] <= 16'h0000;
			end else if (ce) begin
				if (postedHit[i]) begin
					pending[i] <= 1'b1;
					syncCount[i] <= 8'(SYNC_DELAY);
					postedData[i] <= pwdata[15:0];
				end else if (syncFinish[i]) begin
					pending[i] <= 1'b0;
					syncCount[i] <= 8'h00;
				end else if (pending[i]) begin
					syncCount[i] <= syncCount[i] - 8'h01;
				end
			end
		end
	end

	// completion pulses to the always-on registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			postedWriteDone <= 7'h00;
		end else if (ce) begin
			postedWriteDone <= syncFinish;
		end
	end

	// ----------------------------------------
	// sticky flag, visibility, interrupts
	// ----------------------------------------
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wsyncFlag <= 1'b0;
		end else if (ce) begin
			if (|syncFinish) begin
				wsyncFlag <= 1'b1;
			end else if (statusWrite && pwdata[`RSWS_BIT_WSYNC_FLAG]) begin
				wsyncFlag <= 1'b0;
			end
		end
	end

	// isolation state sampled each cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alwaysOnVisible <= 1'b0;
		end else if (ce) begin
			alwaysOnVisible <= alwaysOnVisibleIn;
		end
	end

	// event bits cleared by a read, events win over the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= 2'h0;
		end else if (ce) begin
			irqStatus <= ((rdDone && paddr == `RSWS_OFF_IRQ_STAT) ? 2'h0 : irqStatus)
				| {|syncFinish, snapLoad};
		end
	end

	// interrupt mask
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqMask <= 2'h0;
		end else if (ce && wrDone && paddr == `RSWS_OFF_IRQ_MASK) begin
			irqMask <= pwdata[1:0];
		end
	end

	// level interrupt from registered status
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irqStatus & irqMask);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	localparam int SYNC_MAX = 260;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || !ce);

	// snapshot loading and holding
	key_loads_snap_a: assert property (keyWrite |=> snapLow == $past(counterLowWord)
		&& snapMid == $past(counterMidWord) && snapHigh == $past(counterHighWord))
		else $error("key write did not load snapshots");
	cap_loads_snap_a: assert property (captureLoad |=> snapLow == $past(counterLowWord))
		else $error("capture did not load snapshot");
	cap_loads_all_a: assert property (captureLoad |=> snapMid == $past(counterMidWord)
		&& snapHigh == $past(counterHighWord))
		else $error("capture did not load upper snapshots");
	cap_no_overwrite_a: assert property (captureEvent && !keyWrite
		&& !captureControl[`RSWS_CAP_OW_BIT] |=> $stable(snapLow) && $stable(snapMid))
		else $error("capture replaced snapshot without permission");
	snap_holds_a: assert property (!snapLoad |=> $stable(snapLow) && $stable(snapMid)
		&& $stable(snapHigh))
		else $error("snapshot changed without event");

	// snapshot reads, skipped when a capture lands mid-transfer, and status reads
	low_read_a: assert property (rdDone && !$past(snapLoad)
		&& paddr == `RSWS_OFF_SNAP_LOW |-> prdata == {16'h0000, snapLow})
		else $error("low snapshot read wrong");
	mid_read_a: assert property (rdDone && !$past(snapLoad)
		&& paddr == `RSWS_OFF_SNAP_MID |-> prdata == {16'h0000, snapMid})
		else $error("middle snapshot read wrong");
	high_read_width_a: assert property (rdDone && !$past(snapLoad)
		&& paddr == `RSWS_OFF_SNAP_HIGH
		|-> prdata[31:15] == 17'h0_0000 && prdata[14:0] == snapHigh)
		else $error("upper snapshot read wrong");
	status_zero_a: assert property (rdDone && paddr == `RSWS_OFF_STATUS
		|-> prdata[31:15] == 17'h0_0000 && prdata[6] == 1'b0 && prdata[4:0] == 5'h00)
		else $error("unused status bits not zero");
	visible_bit_a: assert property (setupPhase && !pwrite
		&& paddr == `RSWS_OFF_STATUS |=> prdata[14] == $past(alwaysOnVisible))
		else $error("visibility bit wrong");
	visible_follows_a: assert property (
		1'b1 |=> alwaysOnVisible == $past(alwaysOnVisibleIn))
		else $error("visibility not sampled");

	// posted-write sync bits
	trim_pending_a: assert property (wrDone && paddr == `RSWS_OFF_TRIM
		|=> !statusWord[13])
		else $error("trim sync bit not cleared");
	trim_resolves_a: assert property (wrDone && paddr == `RSWS_OFF_TRIM
		|-> ##[1:SYNC_MAX] statusWord[13])
		else $error("trim sync never visible");
	ctrl_pending_a: assert property (wrDone && paddr == `RSWS_OFF_CTRL
		|=> !statusWord[`RSWS_BIT_SYNC_FIRST]
		##1 (!statusWord[`RSWS_BIT_SYNC_FIRST] || SYNC_DELAY == 1))
		else $error("control sync bit not cleared");
	ctrl_restart_a: assert property (postedHit[RSWS_TGT_CTRL]
		|=> pending[RSWS_TGT_CTRL] && syncCount[RSWS_TGT_CTRL] == 8'(SYNC_DELAY))
		else $error("control crossing delay not restarted");

	// sticky flag, interrupts and bus answer
	flag_sets_a: assert property (|syncFinish
		|=> wsyncFlag && postedWriteDone != 7'h00)
		else $error("sync flag not set");
	flag_clears_a: assert property (statusWrite && pwdata[`RSWS_BIT_WSYNC_FLAG]
		&& syncFinish == 7'h00 |=> !wsyncFlag)
		else $error("sync flag not cleared by write-one");
	irq_level_a: assert property (1'b1 |=> irq == |$past(irqStatus & irqMask))
		else $error("interrupt level wrong");
	irq_read_clears_a: assert property (rdDone && paddr == `RSWS_OFF_IRQ_STAT
		&& !snapLoad && syncFinish == 7'h00 |=> irqStatus == 2'h0)
		else $error("interrupt status not cleared by read");
	unmapped_err_a: assert property (setupPhase && !addrOk |=> pready && pslverr)
		else $error("unmapped access not flagged");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held beyond one cycle");

	// main scenarios reached
	key_snap_c: cover property (keyWrite ##[2:6] rdDone && paddr == `RSWS_OFF_SNAP_LOW);
	cap_snap_c: cover property (captureLoad);
	sync_done_c: cover property (postedHit[RSWS_TGT_TRIM] ##[1:20] syncFinish[RSWS_TGT_TRIM]);
	irq_rise_c: cover property ($rose(irq));
endmodule // rsws_core
`default_nettype wire

// File: sim/rsws_core_tb.sv
// self-checking testbench for the snapshot and write-sync status block
`timescale 1ns/1ps
`default_nettype none
`include "rsws_consts.svh"

module rsws_core_tb import rsws_pkg::*; ;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk, rst, ce, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata; // read data from the block
	logic pready, pslverr, irq, captureEvent, alwaysOnVisibleIn;
	rsws_word_t counterLowWord, counterMidWord;
	logic [14:0] counterHighWord;
	logic [6:0] postedWriteDone;
	logic [6:0] seenDone; // every completion pulse seen
	logic [31:0] rdat;
	logic rerr;
	int err_count, num_checks;
	logic [7:0] tgt [7]; // posted targets in status-bit order
	logic [15:0] st; // expected status word

	// ----------------------------------------
	// device, slow sync so a pending bit can be read
	// ----------------------------------------
	rsws_core #(.SYNC_DELAY(8), .HIGH_BITS(15)) rsws_core_i (
		.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .counterLowWord(counterLowWord),
		.counterMidWord(counterMidWord), .counterHighWord(counterHighWord),
		.captureEvent(captureEvent), .alwaysOnVisibleIn(alwaysOnVisibleIn),
		.postedWriteDone(postedWriteDone), .irq(irq)
	);

	// clock at 40 MHz
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// collects completion pulses
	always @(posedge core_clk or posedge rst) begin
		if (rst) seenDone <= 7'h00;
		else seenDone <= seenDone | postedWriteDone;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rdat, rerr);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, rdat, rerr);
		chk(rdat, exp);
	endtask

	// reads the three snapshots as one 47-bit value
	task automatic sn(input logic [46:0] v);
		rd(`RSWS_OFF_SNAP_LOW, {16'h0000, v[15:0]});
		rd(`RSWS_OFF_SNAP_MID, {16'h0000, v[31:16]});
		rd(`RSWS_OFF_SNAP_HIGH, {17'h00000, v[46:32]});
	endtask

	task automatic pulse();
		@(posedge core_clk);
		captureEvent <= 1'b1;
		@(posedge core_clk);
		captureEvent <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, ce, psel, penable, pwrite, captureEvent} = 6'b110000;
		{paddr, pwdata, err_count, num_checks} = '0;
		alwaysOnVisibleIn = 1'b1;
		{counterHighWord, counterMidWord, counterLowWord} = 47'h4B6D_1E2F_A5C3;
		tgt = '{`RSWS_OFF_CTRL, `RSWS_OFF_STATUS, `RSWS_OFF_CNT_LOW, `RSWS_OFF_CNT_MID,
			`RSWS_OFF_ALARM_A, `RSWS_OFF_ALARM_B, `RSWS_OFF_TRIM};
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		// idle status: all sync bits set, visible
		rd(`RSWS_OFF_STATUS, 32'h7F80);
		alwaysOnVisibleIn <= 1'b0;
		rd(`RSWS_OFF_STATUS, 32'h3F80);
		alwaysOnVisibleIn <= 1'b1;
		sn(47'h0);
		// wrong key leaves snapshots, right key loads them
		wr(`RSWS_OFF_GATEWAY, 32'h7626);
		sn(47'h0);
		wr(`RSWS_OFF_IRQ_MASK, 32'h1);
		wr(`RSWS_OFF_GATEWAY, 32'h7627);
		sn(47'h4B6D_1E2F_A5C3);
		chk({31'h0, irq}, 32'h1);
		rd(`RSWS_OFF_IRQ_STAT, 32'h1);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(`RSWS_OFF_SNAP_LOW, 32'hFFFF);
		sn(47'h4B6D_1E2F_A5C3);
		// capture without overwrite permission is ignored
		{counterHighWord, counterMidWord, counterLowWord} <= 47'h12A4_7C91_0E3B;
		wr(`RSWS_OFF_CAPCTRL, 32'h1);
		pulse();
		sn(47'h4B6D_1E2F_A5C3);
		wr(`RSWS_OFF_CAPCTRL, 32'h3);
		pulse();
		sn(47'h12A4_7C91_0E3B);
		// each posted target clears its sync bit until it settles
		for (int i = 0; i < 7; i++) begin
			wr(tgt[i], 32'h4C00 | i);
			st = 16'h7F80 ^ (16'h0080 << i);
			rd(`RSWS_OFF_STATUS, {16'h0, st | ((i > 0) ? 16'h0020 : 16'h0)});
			repeat (12) @(posedge core_clk);
			rd(`RSWS_OFF_STATUS, 32'h7FA0);
			if (i != 1) rd(tgt[i], 32'h4C00 | i);
		end
		chk({25'h0, seenDone}, 32'h7F);
		// write-one clears the sync flag, the status write then re-sets it
		wr(`RSWS_OFF_STATUS, 32'h20);
		rd(`RSWS_OFF_STATUS, 32'h7E80);
		repeat (12) @(posedge core_clk);
		rd(`RSWS_OFF_STATUS, 32'h7FA0);
		// clock enable low freezes a pending crossing
		wr(`RSWS_OFF_TRIM, 32'h1234);
		ce <= 1'b0;
		repeat (20) @(posedge core_clk);
		ce <= 1'b1;
		rd(`RSWS_OFF_STATUS, 32'h5FA0);
		repeat (12) @(posedge core_clk);
		rd(`RSWS_OFF_STATUS, 32'h7FA0);
		rd(`RSWS_OFF_TRIM, 32'h1234);
		// sync event raises the interrupt when unmasked; capture event still held
		wr(`RSWS_OFF_IRQ_MASK, 32'h2);
		rd(`RSWS_OFF_IRQ_STAT, 32'h3);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(`RSWS_OFF_CTRL, 32'h5);
		repeat (12) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		rd(`RSWS_OFF_IRQ_STAT, 32'h2);
		// unmapped address is refused
		xfer(1'b0, 8'hFC, 32'h0, rdat, rerr);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		conclude();
	end
endmodule // rsws_core_tb
`default_nettype wire
